// ---- rss_pkg.sv ----
`default_nettype none
package rss_pkg;
    // Register indices on the plain register port
    localparam logic [1:0] ADDR_BROWNOUT_CONTROL = 2'h0;
    localparam logic [1:0] ADDR_POWER_CONTROL    = 2'h1;
    localparam logic [1:0] ADDR_STATUS           = 2'h2;
    localparam logic [1:0] ADDR_CONFIG           = 2'h3;

    // Brown-out control fields
    localparam int BC_SW_ENABLE_BIT = 7;
    localparam int BC_RESERVED_BIT  = 6;
    localparam int BC_READY_BIT     = 0;

    // Power control fields
    localparam int PC_STACK_OVER_BIT  = 7;
    localparam int PC_STACK_UNDER_BIT = 6;
    localparam int PC_WDT_BIT         = 4;
    localparam int PC_PIN_BIT         = 3;
    localparam int PC_INSTR_BIT       = 2;
    localparam int PC_POR_BIT         = 1;
    localparam int PC_BOR_BIT         = 0;

    // Status fields
    localparam int ST_EXPIRY_BIT     = 1;
    localparam int ST_POWER_DOWN_BIT = 0;

    // Reset values
    localparam logic [7:0] BC_RESET_VALUE = 8'h80;
    localparam logic [7:0] PC_POR_VALUE   = 8'h1c;
    localparam logic [1:0] ST_POR_VALUE   = 2'h3;

    // Timing
    localparam int CLK_HZ          = 10_000_000;
    localparam int POWER_UP_MS     = 64;
    localparam int POWER_UP_CYCLES = POWER_UP_MS * (CLK_HZ / 1000);
    localparam int PIN_RELEASE_CYCLES = 10;
    localparam int GLITCH_CYCLES   = 4;

    localparam logic [15:0] RESET_VECTOR = 16'h0000;
    localparam logic [15:0] IRQ_VECTOR   = 16'h0004;
    localparam logic [1:0]  BOR_MODE_SOFTWARE = 2'h1;
    localparam logic [1:0]  BOR_MODE_OFF      = 2'h0;
    localparam logic [1:0]  BOR_MODE_NO_SLEEP = 2'h2;
endpackage
`default_nettype wire

// ---- rss_counter.sv ----
`timescale 1ns/1ps
`default_nettype none
// Counts while run is high, clears when run low; done once limit is reached
module rss_counter #(
    parameter int WIDTH = 16,
    parameter int LIMIT = 10
) (
    input  wire logic core_clk,  // System clock
    input  wire logic arst_n,    // Async reset
    input  wire logic run,       // Count enable, clear when low
    output logic      done       // Limit reached
);
    logic [WIDTH-1:0] count_q;

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            count_q <= '0;
        end
        else if (!run)
        begin
            count_q <= '0;
        end
        else if (count_q != WIDTH'(LIMIT))
        begin
            count_q <= count_q + WIDTH'(1);
        end
    end

    assign done = run && (count_q == WIDTH'(LIMIT));
endmodule
`default_nettype wire

// ---- rss_glitch_filter.sv ----
`timescale 1ns/1ps
`default_nettype none
// Output follows input only after it is stable for STABLE cycles
module rss_glitch_filter #(
    parameter int STABLE = 4
) (
    input  wire logic core_clk,  // System clock
    input  wire logic arst_n,    // Async reset
    input  wire logic pinIn,     // Raw level
    output logic      pinOut     // Filtered level
);
    logic [7:0] stable_q;
    logic       out_q;

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stable_q <= 8'h00;
            out_q    <= 1'b1;
        end
        else if (pinIn == out_q)
        begin
            stable_q <= 8'h00;
        end
        else if (stable_q == 8'(STABLE - 1))
        begin
            out_q    <= pinIn;
            stable_q <= 8'h00;
        end
        else
        begin
            stable_q <= stable_q + 8'h01;
        end
    end

    assign pinOut = out_q;
endmodule
`default_nettype wire

// ---- rss_reset_source_sequencer.sv ----
// Operation
// R1: Both brown-out requests form one brown-out flag
// R2: Low-power brown-out enable bit, erased means off
// R3: Pin reset off only when both bits zero
// R4: Pin low holds reset; weak pull-up on
// R5: Short pin glitches are filtered out
// R6: Internal reset never drives pin
// R7: Disabled pin is input, software pull-up
// R8: Watchdog expiry resets, updates status flags
// R9: Reset instruction resets, clears its flag
// R10: Stack faults reset only when enabled
// R11: Programming exit acts as power-on
// R12: Power-up timer holds reset 64 ms
// R13: Timer starts after power-on and brown-out release
// R14: Start waits for timer, pin, oscillator
// R15: Start ten cycles after late pin release
// R16: Reset vector zero, wake continues next address
// R17: Interrupt wake with enable goes to vector four
// R18: Power-on sets defined status and flags
// R19: Brown-out sets defined status and flags
// R20: Pin reset clears its flag; sleep variant
// R21: Watchdog reset and wake status updates
// R22: Software brown-out enable only in mode 01
// R23: Ready bit shows brown-out circuit active
// R24: Flags change only on own cause
// R25: Software may set flags, no reset
// R26: Combined reset released synchronously
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module rss_reset_source_sequencer #(
    parameter int POWER_UP_CYCLES = rss_pkg::POWER_UP_CYCLES
) (
    input  wire logic        core_clk,        // System clock
    input  wire logic        arst_n,          // Power-on reset, async
    input  wire logic        lowPowerBorReq,  // Low-power brown-out request
    input  wire logic        brownoutReq,     // Brown-out request
    input  wire logic        brownoutActive,  // Brown-out circuit ready/active
    input  wire logic        masterClearPin,  // External reset pin level
    input  wire logic        watchdogExpire,  // Watchdog timeout pulse
    input  wire logic        resetInstr,      // Reset instruction pulse
    input  wire logic        stackOver,       // Stack overflow pulse
    input  wire logic        stackUnder,      // Stack underflow pulse
    input  wire logic        progExit,        // Programming mode exit pulse
    input  wire logic        oscStartDone,    // Oscillator start-up complete
    input  wire logic        sleeping,        // Core asleep
    input  wire logic        wakeIrq,         // Interrupt wake pulse
    input  wire logic        globalIrqEnable, // Global interrupt enable
    input  wire logic [15:0] currentPc,       // Program counter in sleep
    input  wire logic        swPullUp,        // Software pull-up for GPIO use
    input  wire logic        cfgLowPowerBor,  // Low-power brown-out config bit
    input  wire logic        cfgClearPinEn,   // Pin reset enable config bit
    input  wire logic        cfgLowVoltProg,  // Low-voltage programming bit
    input  wire logic        cfgStackFaultEn, // Stack fault reset enable
    input  wire logic        cfgPowerUpEn_n,  // Power-up timer enable, low
    input  wire logic [1:0]  cfgBorMode,      // Brown-out mode config
    input  wire logic [1:0]  regAddr,         // Register address
    input  wire logic [7:0]  regWdata,        // Write data
    input  wire logic        regWr,           // Write strobe
    input  wire logic        regRd,           // Read strobe
    output logic      [7:0]  regRdata,        // Read data, cycle after strobe
    output logic             coreReset,       // Combined reset to core
    output logic             brownoutEnable,  // Brown-out circuit enable
    output logic             pinPullUp,       // Weak pull-up on pin
    output logic             pinGpio,         // Filtered pin as GPIO input
    output logic      [15:0] pcLoad,          // Program counter to load
    output logic             pcLoadStrobe,    // Load pcLoad this cycle
    output logic             pushReturn       // Push return address
);
    logic borAny;
    logic pinEnable;
    logic pinFilt;
    logic pinHold;
    logic stackFault;
    logic resetEvt;
    logic porEvt;
    logic borEvt_q;
    logic pwrtDone;
    logic releaseDone;
    logic holdNow;

    logic       swBorEn_q;
    logic       reservedBit_q;
    logic [7:0] pcon_q;
    logic [1:0] status_q;
    logic       porPend_q;
    logic       pwrtRun_q;
    logic       pinPrev_q;
    logic       waitPin_q;
    logic       reset_q;
    logic [7:0] rdata_q;
    logic       pullUp_q;
    logic       gpio_q;
    logic       bore_q;
    logic [15:0] pc_q;
    logic       pcStb_q;
    logic       push_q;

    // ************
    // Reset request combination
    // ************
    assign borAny     = (cfgLowPowerBor & lowPowerBorReq) | brownoutReq; // [R1] [R2]
    assign pinEnable  = cfgClearPinEn | cfgLowVoltProg;                  // [R3]
    assign pinHold    = pinEnable & ~pinFilt;                            // [R4]
    assign stackFault = cfgStackFaultEn & (stackOver | stackUnder);      // [R10]
    assign porEvt     = progExit;                                        // [R11]
    assign resetEvt   = porEvt | borAny | (watchdogExpire & ~sleeping) | resetInstr | stackFault;

    rss_glitch_filter #(
        .STABLE (rss_pkg::GLITCH_CYCLES)
    ) u_filter (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .pinIn    (masterClearPin),
        .pinOut   (pinFilt)      // [R5]
    );

    // ************
    // Start-up timers
    // ************
    rss_counter #(
        .WIDTH (20),
        .LIMIT (POWER_UP_CYCLES)
    ) u_power_up_timer (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .run      (pwrtRun_q & ~borAny),  // [R13]
        .done     (pwrtDone)
    );

    rss_counter #(
        .WIDTH (4),
        .LIMIT (rss_pkg::PIN_RELEASE_CYCLES)
    ) u_release (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .run      (waitPin_q & ~pinHold),
        .done     (releaseDone)     // [R15]
    );

    // Power-up timer phase after power-on or brown-out
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            porPend_q <= 1'b1;
            pwrtRun_q <= 1'b0;
        end
        else if (porEvt | borAny)
        begin
            porPend_q <= 1'b1;
            pwrtRun_q <= 1'b0;
        end
        else if (porPend_q)
        begin
            porPend_q <= 1'b0;
            pwrtRun_q <= ~cfgPowerUpEn_n;   // [R12]
        end
        else if (pwrtDone)
        begin
            pwrtRun_q <= 1'b0;
        end
    end

    // Pin release delay: armed while pin holds reset
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            waitPin_q <= 1'b0;
            pinPrev_q <= 1'b0;
        end
        else
        begin
            pinPrev_q <= pinHold;
            if (pinHold)
            begin
                waitPin_q <= 1'b1;
            end
            else if (releaseDone)
            begin
                waitPin_q <= 1'b0;
            end
        end
    end

    assign holdNow = resetEvt | porPend_q | pwrtRun_q | pinHold | waitPin_q
                   | ~oscStartDone;  // [R14] [R26]

    // ************
    // Combined reset and program counter
    // ************
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            reset_q <= 1'b1;
            pc_q    <= rss_pkg::RESET_VECTOR;
            pcStb_q <= 1'b0;
            push_q  <= 1'b0;
        end
        else
        begin
            reset_q <= holdNow;                          // [R26]
            pcStb_q <= 1'b0;
            push_q  <= 1'b0;
            if (holdNow)
            begin
                pc_q    <= rss_pkg::RESET_VECTOR;        // [R16]
                pcStb_q <= 1'b1;
            end
            else if (sleeping && (wakeIrq || watchdogExpire))
            begin
                pc_q    <= currentPc + 16'h0001;         // [R16]
                pcStb_q <= 1'b1;
                push_q  <= wakeIrq & globalIrqEnable;   // [R17]
            end
            else if (push_q)
            begin
                pc_q    <= rss_pkg::IRQ_VECTOR;          // [R17]
                pcStb_q <= 1'b1;
            end
        end
    end

    // ************
    // Cause flags and status bits
    // ************
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pcon_q   <= rss_pkg::PC_POR_VALUE;   // [R18]
            status_q <= rss_pkg::ST_POR_VALUE;   // [R18]
        end
        else if (porEvt)
        begin
            pcon_q   <= rss_pkg::PC_POR_VALUE;   // [R11] [R18]
            status_q <= rss_pkg::ST_POR_VALUE;
        end
        else if (borAny)
        begin
            pcon_q[rss_pkg::PC_STACK_OVER_BIT]  <= 1'b0;  // [R19]
            pcon_q[rss_pkg::PC_STACK_UNDER_BIT] <= 1'b0;
            pcon_q[rss_pkg::PC_WDT_BIT]         <= 1'b1;
            pcon_q[rss_pkg::PC_PIN_BIT]         <= 1'b1;
            pcon_q[rss_pkg::PC_INSTR_BIT]       <= 1'b1;
            pcon_q[rss_pkg::PC_BOR_BIT]         <= 1'b0;  // [R1]
            status_q <= rss_pkg::ST_POR_VALUE;
        end
        else
        begin
            // Software write first; hardware causes win below [R25]
            if (regWr && regAddr == rss_pkg::ADDR_POWER_CONTROL)
            begin
                pcon_q <= regWdata & 8'hdf;
            end
            if (regWr && regAddr == rss_pkg::ADDR_STATUS)
            begin
                status_q <= regWdata[1:0];
            end
            if (watchdogExpire)
            begin
                status_q[rss_pkg::ST_EXPIRY_BIT] <= 1'b0;            // [R8] [R21]
                if (sleeping)
                begin
                    status_q[rss_pkg::ST_POWER_DOWN_BIT] <= 1'b0;   // [R21]
                end
                else
                begin
                    pcon_q[rss_pkg::PC_WDT_BIT] <= 1'b0;            // [R8] [R24]
                end
            end
            if (resetInstr)
            begin
                pcon_q[rss_pkg::PC_INSTR_BIT] <= 1'b0;              // [R9]
            end
            if (stackFault && stackOver)
            begin
                pcon_q[rss_pkg::PC_STACK_OVER_BIT] <= 1'b1;         // [R10]
            end
            if (stackFault && stackUnder)
            begin
                pcon_q[rss_pkg::PC_STACK_UNDER_BIT] <= 1'b1;        // [R10]
            end
            if (pinHold && !pinPrev_q)
            begin
                pcon_q[rss_pkg::PC_PIN_BIT] <= 1'b0;                // [R20]
                if (sleeping)
                begin
                    status_q <= 2'h2;                               // [R20]
                end
            end
            if (wakeIrq && sleeping)
            begin
                status_q <= 2'h2;
            end
        end
    end

    // ************
    // Brown-out control register
    // ************
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            swBorEn_q     <= rss_pkg::BC_RESET_VALUE[rss_pkg::BC_SW_ENABLE_BIT];
            reservedBit_q <= rss_pkg::BC_RESET_VALUE[rss_pkg::BC_RESERVED_BIT];
        end
        else if (porEvt | borAny)
        begin
            reservedBit_q <= 1'b0;
        end
        else if (regWr && regAddr == rss_pkg::ADDR_BROWNOUT_CONTROL)
        begin
            swBorEn_q     <= regWdata[rss_pkg::BC_SW_ENABLE_BIT];
            reservedBit_q <= regWdata[rss_pkg::BC_RESERVED_BIT];
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bore_q <= 1'b1;
        end
        else
        begin
            unique case (cfgBorMode)
                rss_pkg::BOR_MODE_OFF:      bore_q <= 1'b0;
                rss_pkg::BOR_MODE_SOFTWARE: bore_q <= swBorEn_q;   // [R22]
                rss_pkg::BOR_MODE_NO_SLEEP: bore_q <= ~sleeping;
                default:                    bore_q <= 1'b1;
            endcase
        end
    end

    // ************
    // Pin and read port
    // ************
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pullUp_q <= 1'b1;
            gpio_q   <= 1'b1;
        end
        else
        begin
            pullUp_q <= pinEnable | swPullUp;  // [R4] [R7] [R6]
            gpio_q   <= pinFilt;               // [R7]
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rdata_q <= 8'h00;
        end
        else if (regRd)
        begin
            unique case (regAddr)
                rss_pkg::ADDR_BROWNOUT_CONTROL:
                    rdata_q <= {swBorEn_q, reservedBit_q, 5'h00, brownoutActive}; // [R23]
                rss_pkg::ADDR_POWER_CONTROL:
                    rdata_q <= pcon_q;
                rss_pkg::ADDR_STATUS:
                    rdata_q <= {6'h00, status_q};
                rss_pkg::ADDR_CONFIG:
                    rdata_q <= {cfgBorMode, cfgPowerUpEn_n, cfgStackFaultEn,
                                cfgLowVoltProg, cfgClearPinEn, cfgLowPowerBor, 1'b0};
            endcase
        end
        else
        begin
            rdata_q <= 8'h00;
        end
    end

    assign regRdata       = rdata_q;
    assign coreReset      = reset_q;
    assign brownoutEnable = bore_q;
    assign pinPullUp      = pullUp_q;
    assign pinGpio        = gpio_q;
    assign pcLoad         = pc_q;
    assign pcLoadStrobe   = pcStb_q;
    assign pushReturn     = push_q;
endmodule
`default_nettype wire

// ---- rss_supply_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ************
// Pin driver and supply monitor model
// ************
module rss_supply_model (
    input  wire logic core_clk,  // System clock
    input  wire logic pinHold,   // Hold pin low
    input  wire logic dipLow,    // Low-power monitor trips
    input  wire logic dipMain,   // Main monitor trips
    input  wire logic borEnable, // Circuit enable from block
    output logic      pinLevel,  // Pin level
    output logic      lpReq,     // Low-power request
    output logic      borReq,    // Main request
    output logic      borActive  // Circuit active
);
    always_ff @(posedge core_clk)
    begin
        pinLevel  <= !pinHold;              // Pull-up wins when released
        lpReq     <= dipLow;
        borReq    <= dipMain && borActive;  // Only an active circuit trips
        borActive <= borEnable;
    end
endmodule
`default_nettype wire

// ---- rss_sequencer_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module rss_sequencer_asserts #(
    parameter int POWER_UP_CYCLES = 20
) (
    input wire logic        core_clk,        // Clock
    input wire logic        arst_n,          // Reset
    input wire logic        watchdogExpire,  // Watchdog pulse
    input wire logic        resetInstr,      // Instruction pulse
    input wire logic        stackOver,       // Overflow pulse
    input wire logic        stackUnder,      // Underflow pulse
    input wire logic        masterClearPin,  // Pin level
    input wire logic        sleeping,        // Asleep
    input wire logic        wakeIrq,         // Wake pulse
    input wire logic        globalIrqEnable, // Interrupt enable
    input wire logic [15:0] currentPc,       // Sleep PC
    input wire logic        cfgClearPinEn,   // Pin enable
    input wire logic        cfgLowVoltProg,  // Low-voltage prog
    input wire logic        cfgStackFaultEn, // Stack enable
    input wire logic        cfgPowerUpEn_n,  // Timer enable
    input wire logic [1:0]  cfgBorMode,      // Brown-out mode
    input wire logic [1:0]  regAddr,         // Address
    input wire logic [7:0]  regWdata,        // Write data
    input wire logic        regWr,           // Write strobe
    input wire logic        regRd,           // Read strobe
    input wire logic        brownoutActive,  // Circuit active
    input wire logic [7:0]  regRdata,        // Read data
    input wire logic        coreReset,       // Core reset
    input wire logic        brownoutEnable,  // Circuit enable
    input wire logic [15:0] pcLoad,          // PC load value
    input wire logic        pcLoadStrobe,    // PC load strobe
    input wire logic        pushReturn       // Push strobe
);
    // ************
    // Cycles since power-on release
    // ************
    int unsigned sinceRst;
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sinceRst <= 0;
        end
        else if (sinceRst < 32'hffff)
        begin
            sinceRst <= sinceRst + 1;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    sequence s_sw_write(bit v);
        regWr && regAddr == rss_pkg::ADDR_BROWNOUT_CONTROL && cfgBorMode == 2'h1
            && regWdata[rss_pkg::BC_SW_ENABLE_BIT] == v;
    endsequence
    sequence s_irq_wake;
        sleeping && wakeIrq && globalIrqEnable;
    endsequence
    sequence s_vector;
        pushReturn ##1 pcLoadStrobe && pcLoad == rss_pkg::IRQ_VECTOR;
    endsequence

    // ************
    // Properties
    // ************
    a_instr_reset: assert property (resetInstr && !coreReset |=> coreReset)
        else $error("reset instruction did not reset");
    a_instr_vector: assert property (resetInstr && !coreReset |=> pcLoadStrobe && pcLoad == 16'h0)
        else $error("reset did not load vector zero");
    a_wdt_reset: assert property (watchdogExpire && !sleeping && !coreReset |=> coreReset)
        else $error("watchdog expiry did not reset");
    a_stack_reset: assert property ((stackOver || stackUnder) && cfgStackFaultEn && !coreReset |=> coreReset)
        else $error("stack fault did not reset");
    a_pin_hold: assert property (((cfgClearPinEn || cfgLowVoltProg) && !masterClearPin) [*8] |-> coreReset)
        else $error("low pin did not hold reset");
    a_power_up_hold: assert property ($fell(coreReset) && !cfgPowerUpEn_n |-> sinceRst >= POWER_UP_CYCLES)
        else $error("reset released before power-up time");
    a_ready_bit: assert property (regRd && regAddr == 2'h0 |=> regRdata[0] == $past(brownoutActive))
        else $error("ready bit differs from circuit state");
    a_sw_on: assert property (s_sw_write(1'b1) |-> ##[1:2] brownoutEnable)
        else $error("software enable did not start circuit");
    a_sw_off: assert property (s_sw_write(1'b0) |-> ##[1:2] !brownoutEnable)
        else $error("software disable did not stop circuit");
    a_wake_next: assert property (sleeping && wakeIrq |=> pcLoadStrobe && pcLoad == $past(currentPc) + 16'h1)
        else $error("wake did not continue at next address");
    a_wake_irq: assert property (s_irq_wake |=> s_vector)
        else $error("interrupt wake did not vector");
endmodule

bind rss_reset_source_sequencer rss_sequencer_asserts #(.POWER_UP_CYCLES(POWER_UP_CYCLES)) u_chk (
    .*
);
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int PU = 20;
    logic        core_clk = 1'b0, arst_n, sleeping, globalIrqEnable, swPullUp, oscStartDone;
    logic        cfgLowPowerBor, cfgClearPinEn, cfgLowVoltProg, cfgStackFaultEn, cfgPowerUpEn_n;
    logic        regWr, regRd, pinHold, dipLow, dipMain, coreReset, brownoutEnable;
    logic        masterClearPin, lowPowerBorReq, brownoutReq, brownoutActive;
    logic        pcLoadStrobe, pushReturn, pinPullUp, pinGpio;
    logic [1:0]  cfgBorMode, regAddr;
    logic [7:0]  regWdata, regRdata;
    logic [15:0] currentPc, pcLoad;
    logic [5:0]  pulses;
    int          fails = 0, comparisons = 0, cyc = 0, n;

    always #50 core_clk = !core_clk;

    rss_reset_source_sequencer #(.POWER_UP_CYCLES(PU)) dut (
        .core_clk, .arst_n, .lowPowerBorReq, .brownoutReq, .brownoutActive, .masterClearPin,
        .watchdogExpire(pulses[0]), .resetInstr(pulses[1]), .stackOver(pulses[2]),
        .stackUnder(pulses[3]), .progExit(pulses[4]), .wakeIrq(pulses[5]), .oscStartDone,
        .sleeping, .globalIrqEnable, .currentPc, .swPullUp, .cfgLowPowerBor, .cfgClearPinEn,
        .cfgLowVoltProg, .cfgStackFaultEn, .cfgPowerUpEn_n, .cfgBorMode, .regAddr, .regWdata,
        .regWr, .regRd, .regRdata, .coreReset, .brownoutEnable, .pinPullUp, .pinGpio,
        .pcLoad, .pcLoadStrobe, .pushReturn
    );

    rss_supply_model partner (
        .core_clk, .pinHold, .dipLow, .dipMain, .borEnable(brownoutEnable),
        .pinLevel(masterClearPin), .lpReq(lowPowerBorReq), .borReq(brownoutReq),
        .borActive(brownoutActive)
    );

    // ************
    // Tasks
    // ************
    task automatic close_out;
        if (fails == 0 && comparisons > 0)
        begin
            $display("TB: PASS");
        end
        else
        begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1;
        chk(16'(regRdata), 16'(e));
    endtask

    task automatic pulse(input int i);
        pulses[i] <= 1'b1;
        @(posedge core_clk);
        pulses <= '0;
        #1;
    endtask

    task automatic waitRun(output int k);
        k = 0;
        while (coreReset !== 1'b0 && k < 500)
        begin
            tick(1);
            k++;
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask

    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            fails++;
            close_out();
        end
    end

    // ************
    // Sequence
    // ************
    initial
    begin
        {arst_n, sleeping, globalIrqEnable, swPullUp, oscStartDone, regWr, regRd} = '0;
        {pinHold, dipLow, dipMain, cfgLowVoltProg, cfgPowerUpEn_n} = '0;
        {cfgLowPowerBor, cfgClearPinEn, cfgStackFaultEn} = 3'h7;
        cfgBorMode = 2'h1;
        {regAddr, regWdata, currentPc, pulses} = '0;
        repeat (16) @(posedge core_clk);
        arst_n <= 1'b1;
        tick(30);
        chk(16'(coreReset), 16'h1);
        oscStartDone <= 1'b1;
        waitRun(n);
        rd(2'h1, 8'h1c);
        rd(2'h2, 8'h03);
        rd(2'h0, 8'h81);
        wr(2'h1, 8'hff);
        rd(2'h1, 8'hdf);
        chk(16'(coreReset), 16'h0);
        wr(2'h1, 8'h1f);
        pulse(1);
        waitRun(n);
        rd(2'h1, 8'h1b);
        wr(2'h1, 8'h1f);
        pulse(0);
        waitRun(n);
        rd(2'h1, 8'h0f);
        rd(2'h2, 8'h01);
        for (int i = 2; i < 4; i++)
        begin
            wr(2'h1, 8'h1f);
            pulse(i);
            waitRun(n);
            rd(2'h1, 8'h1f | (8'h80 >> (i - 2)));
        end
        wr(2'h1, 8'h1f);
        pinHold <= 1'b1;
        tick(2);
        pinHold <= 1'b0;
        tick(10);
        chk(16'(coreReset), 16'h0);
        pinHold <= 1'b1;
        tick(20);
        chk(16'(coreReset), 16'h1);
        chk(16'({pinPullUp, pinGpio}), 16'h2);
        pinHold <= 1'b0;
        tick(1);
        waitRun(n);
        chk(16'(n >= 14 && n <= 16), 16'h1);
        rd(2'h1, 8'h17);
        for (int k = 0; k < 2; k++)
        begin
            wr(2'h1, 8'hc1);
            {dipMain, dipLow} <= 2'(k + 1);
            tick(30);
            {dipMain, dipLow} <= 2'h0;
            tick(2);
            waitRun(n);
            chk(16'(n >= PU), 16'h1);
            rd(2'h1, 8'h1c);
            rd(2'h2, 8'h03);
        end
        wr(2'h1, 8'h1f);
        {sleeping, globalIrqEnable, currentPc} <= {2'h3, 16'h1233};
        pulse(5);
        chk(pcLoad, 16'h1234);
        chk(16'(pushReturn), 16'h1);
        tick(1);
        chk(pcLoad, 16'h0004);
        rd(2'h2, 8'h02);
        pulse(0);
        chk(16'(coreReset), 16'h0);
        rd(2'h2, 8'h00);
        rd(2'h1, 8'h1f);
        sleeping <= 1'b0;
        wr(2'h0, 8'h00);
        tick(3);
        chk(16'(brownoutEnable), 16'h0);
        rd(2'h0, 8'h00);
        wr(2'h0, 8'hc0);
        tick(3);
        rd(2'h0, 8'hc1);
        wr(2'h1, 8'hdf);
        pulse(4);
        waitRun(n);
        rd(2'h1, 8'h1c);
        rd(2'h2, 8'h03);
        close_out();
    end
endmodule
`default_nettype wire
